/* File: lock_current_limit_fault.sv */
// Lock current-limit fault response: deglitch, retry, latch and driver state.
`timescale 1ns/100ps
module lock_current_limit_fault #(
  parameter int ADC_W = 12, // Width of the phase current sample.
  parameter int ADC_PER_STEP = 8, // ADC counts per 0.078125 A step.
  parameter int TICK_CYCLES = lock_fault_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [lock_fault_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [ADC_W-1:0] phase_current,
  output lock_fault_pkg::drive_cmd_s drive_cmd,
  output logic fault_out_n
);

  // ===========================================================
  // Reset release
  // ===========================================================
  logic rst_meta_reg; // First stage, read only by the second.
  logic rst_n_reg; // Released reset used by the whole block.

  // Assert at once, release two edges later to avoid metastability.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ===========================================================
  // Helper functions
  // ===========================================================
  // Deglitch time in ticks for a deglitch code.
  function automatic logic [15:0] deg_ticks(input logic [3:0] code);
    deg_ticks = 16'(lock_fault_pkg::DEG_TIME_US[code] /
      lock_fault_pkg::TICK_US);
  endfunction

  // Gate driver state selected by the low bits of a response code.
  function automatic lock_fault_pkg::drv_state_e drv_map(
    input logic [1:0] act);
    unique case (act)
      2'h0: drv_map = lock_fault_pkg::DRV_TRISTATE;
      2'h1: drv_map = lock_fault_pkg::DRV_RECIRC;
      2'h2: drv_map = lock_fault_pkg::DRV_HS_BRAKE;
      2'h3: drv_map = lock_fault_pkg::DRV_LS_BRAKE;
    endcase
  endfunction

  // ===========================================================
  // Registers seen by software
  // ===========================================================
  logic [31:0] settings_reg; // Lock fault settings word.
  logic [15:0] retry_time_reg; // Retry time in ticks.
  logic [3:0] retry_limit_reg; // Retry count limit.
  logic [31:0] rdata_reg; // Read data, valid the cycle after a read.
  lock_fault_pkg::lock_cfg_s cfg; // Decoded settings.

  wire wr_settings = reg_wr && reg_addr == lock_fault_pkg::OFS_SETTINGS;
  wire wr_retry = reg_wr && reg_addr == lock_fault_pkg::OFS_RETRY;
  wire clear_req = reg_wr && reg_addr == lock_fault_pkg::OFS_CLEAR &&
    reg_wdata[lock_fault_pkg::CLR_BIT];

  assign cfg.thr = settings_reg[lock_fault_pkg::THR_LSB +: 4];
  assign cfg.mode = settings_reg[lock_fault_pkg::MODE_LSB +: 4];
  assign cfg.deg = settings_reg[lock_fault_pkg::DEG_LSB +: 4];

  // Configuration writes; all fields are read/write and reset to zero.
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      settings_reg <= lock_fault_pkg::SETTINGS_RST;
      retry_time_reg <= lock_fault_pkg::RTIME_RST;
      retry_limit_reg <= lock_fault_pkg::RLIMIT_RST;
    end else begin
      if (wr_settings) begin
        settings_reg <= reg_wdata;
      end
      if (wr_retry) begin
        retry_time_reg <= reg_wdata[lock_fault_pkg::RTIME_LSB +: 16];
        retry_limit_reg <= reg_wdata[lock_fault_pkg::RLIMIT_LSB +: 4];
      end
    end
  end

  // ===========================================================
  // Threshold compare and deglitch
  // ===========================================================
  logic [15:0] deg_pre_reg; // Cycle prescaler inside one tick.
  logic [15:0] deg_cnt_reg; // Ticks the current has stayed high.
  logic fired_reg; // Event already given for this over-current run.

  // Detection is off for the disabling codes.
  wire det_en = cfg.mode < lock_fault_pkg::MODE_DIS_MIN;
  // Threshold in ADC counts; the compare is inclusive.
  wire over_now = int'(phase_current) >=
    lock_fault_pkg::THR_STEPS[cfg.thr] * ADC_PER_STEP;
  wire run = over_now && det_en;
  wire deg_wrap = deg_pre_reg == 16'(TICK_CYCLES - 1);
  wire [15:0] deg_cnt_inc = deg_cnt_reg + 16'h0001;
  wire deg_done = deg_cnt_inc >= deg_ticks(cfg.deg);
  // One pulse per over-current run, once the deglitch time is met.
  wire lock_event = run && deg_wrap && deg_done && !fired_reg;

  // A drop below threshold restarts both the prescaler and the count,
  // so the deglitch time is always measured from the latest crossing.
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      deg_pre_reg <= 16'h0000;
      deg_cnt_reg <= 16'h0000;
      fired_reg <= 1'b0;
    end else if (!run) begin
      deg_pre_reg <= 16'h0000;
      deg_cnt_reg <= 16'h0000;
      fired_reg <= 1'b0;
    end else begin
      deg_pre_reg <= deg_wrap ? 16'h0000 : deg_pre_reg + 16'h0001;
      if (deg_wrap && !deg_done) begin
        deg_cnt_reg <= deg_cnt_inc;
      end
      if (lock_event) begin
        fired_reg <= 1'b1;
      end
    end
  end

  // ===========================================================
  // Fault state machine
  // ===========================================================
  typedef enum logic [1:0] {ST_IDLE, ST_RETRY, ST_LATCHED} fault_st_e;
  fault_st_e state_reg; // Current fault state.
  fault_st_e state_next;
  logic [1:0] act_reg; // Driver action captured at the event.
  logic [1:0] act_next;
  logic [3:0] retry_cnt_reg; // Retries already spent.
  logic [3:0] retry_cnt_next;
  logic report_reg; // Sticky report-only flag.
  logic report_next;
  logic [15:0] rt_pre_reg; // Cycle prescaler of the retry wait.
  logic [15:0] rt_cnt_reg; // Ticks spent waiting to retry.

  wire mode_latch = cfg.mode < lock_fault_pkg::MODE_RETRY_MIN;
  wire mode_retry = !mode_latch && cfg.mode < lock_fault_pkg::MODE_REPORT;
  wire mode_report = cfg.mode == lock_fault_pkg::MODE_REPORT;
  wire rt_wrap = rt_pre_reg == 16'(TICK_CYCLES - 1);
  wire rt_done = rt_cnt_reg >= retry_time_reg;
  wire retry_over = retry_cnt_reg >= retry_limit_reg;

  // Next state. A new event in the clearing cycle keeps the fault set, except in ST_RETRY, where the clear wins.
  always_comb begin
    state_next = state_reg;
    act_next = act_reg;
    retry_cnt_next = retry_cnt_reg;
    report_next = report_reg && !clear_req;
    unique case (state_reg)
      ST_IDLE: begin
        if (lock_event && mode_latch) begin
          state_next = ST_LATCHED;
          act_next = cfg.mode[1:0];
        end else if (lock_event && mode_retry) begin
          act_next = cfg.mode[1:0];
          state_next = retry_over ? ST_LATCHED : ST_RETRY;
        end
        if (lock_event && mode_report) begin
          report_next = 1'b1;
        end
        if (clear_req && !lock_event) begin
          retry_cnt_next = 4'h0;
        end
      end
      ST_RETRY: begin
        if (clear_req) begin
          state_next = ST_IDLE;
          retry_cnt_next = 4'h0;
        end else if (rt_done) begin
          state_next = ST_IDLE;
          retry_cnt_next = retry_cnt_reg + 4'h1;
        end
      end
      ST_LATCHED: begin
        if (clear_req && !lock_event) begin
          state_next = ST_IDLE;
          retry_cnt_next = 4'h0;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      act_reg <= 2'h0;
      retry_cnt_reg <= 4'h0;
      report_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      act_reg <= act_next;
      retry_cnt_reg <= retry_cnt_next;
      report_reg <= report_next;
    end
  end

  // Retry wait timer; it only runs while a retry is pending.
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rt_pre_reg <= 16'h0000;
      rt_cnt_reg <= 16'h0000;
    end else if (state_reg != ST_RETRY) begin
      rt_pre_reg <= 16'h0000;
      rt_cnt_reg <= 16'h0000;
    end else begin
      rt_pre_reg <= rt_wrap ? 16'h0000 : rt_pre_reg + 16'h0001;
      if (rt_wrap && !rt_done) begin
        rt_cnt_reg <= rt_cnt_reg + 16'h0001;
      end
    end
  end

  // ===========================================================
  // Outputs
  // ===========================================================
  // Outputs follow the next state so they line up with state_reg.
  wire fault_next = state_next != ST_IDLE || report_next;
  lock_fault_pkg::drive_cmd_s drive_next;
  assign drive_next.hold = state_next != ST_IDLE;
  assign drive_next.state = drive_next.hold ? drv_map(act_next) :
    lock_fault_pkg::DRV_NORMAL;

  // Read data: status packs latch, retry, report, count and driver.
  wire [31:0] status_word = {21'h000000, drive_cmd.state, retry_cnt_reg,
    1'b0, report_reg, state_reg == ST_RETRY, state_reg == ST_LATCHED};
  wire [31:0] rd_mux =
    reg_addr == lock_fault_pkg::OFS_SETTINGS ? settings_reg :
    reg_addr == lock_fault_pkg::OFS_RETRY ?
      {12'h000, retry_limit_reg, retry_time_reg} :
    reg_addr == lock_fault_pkg::OFS_STATUS ? status_word : 32'h0000_0000;

  // Output flip-flops; read data stands only in the cycle after a read.
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fault_out_n <= 1'b1;
      drive_cmd <= '{hold: 1'b0, state: lock_fault_pkg::DRV_NORMAL};
      rdata_reg <= 32'h0000_0000;
    end else begin
      fault_out_n <= !fault_next;
      drive_cmd <= drive_next;
      rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_reg;

  // ===========================================================
  // Assertions
  // ===========================================================
  sequence s_retry_start;
    state_reg == ST_IDLE && lock_event && mode_retry && !retry_over;
  endsequence

  property p_latched_pin;
    @(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_LATCHED |-> !fault_out_n && drive_cmd.hold;
  endproperty
  a_latched_pin: assert property (p_latched_pin)
    else $error("Latched fault without fault pin low.");

  property p_latch_drive;
    @(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_IDLE && lock_event && mode_latch |=>
      drive_cmd.state == drv_map($past(cfg.mode[1:0]));
  endproperty
  a_latch_drive: assert property (p_latch_drive)
    else $error("Latched driver state does not match code.");

  property p_retry_clears;
    @(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_RETRY && rt_done && !clear_req |=>
      state_reg == ST_IDLE && retry_cnt_reg == $past(retry_cnt_reg) + 4'h1;
  endproperty
  a_retry_clears: assert property (p_retry_clears)
    else $error("Retry wait did not end after retry time.");

  property p_retry_exhausted;
    @(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_IDLE && lock_event && mode_retry && retry_over |=>
      state_reg == ST_LATCHED ##1 state_reg == ST_LATCHED || clear_req;
  endproperty
  a_retry_exhausted: assert property (p_retry_exhausted)
    else $error("Exhausted retries did not latch the fault.");

  property p_retry_bound;
    @(posedge clk) disable iff (!rst_n_reg)
      s_retry_start |=> state_reg == ST_RETRY && !fault_out_n &&
      retry_cnt_reg < $past(retry_limit_reg);
  endproperty
  a_retry_bound: assert property (p_retry_bound)
    else $error("Retry started beyond the retry limit.");

  property p_report_only;
    @(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_IDLE && lock_event && mode_report |=>
      !fault_out_n && !drive_cmd.hold && state_reg == ST_IDLE;
  endproperty
  a_report_only: assert property (p_report_only)
    else $error("Report-only event acted on the driver.");

  property p_disabled;
    @(posedge clk) disable iff (!rst_n_reg)
      !det_en |-> !lock_event ##1 deg_cnt_reg == 16'h0000;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Lock event raised while detection disabled.");

  property p_deglitch;
    @(posedge clk) disable iff (!rst_n_reg)
      lock_event |-> over_now && deg_pre_reg == 16'(TICK_CYCLES - 1) &&
      deg_cnt_inc >= deg_ticks(cfg.deg);
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("Lock event before the deglitch time.");

  property p_fields;
    @(posedge clk) disable iff (!rst_n_reg)
      wr_settings |=> cfg.mode == $past(reg_wdata[18:15]) &&
      cfg.deg == $past(reg_wdata[14:11]) &&
      cfg.thr == $past(reg_wdata[22:19]);
  endproperty
  a_fields: assert property (p_fields)
    else $error("Settings fields not at their bit positions.");

  property p_restart;
    @(posedge clk) disable iff (!rst_n_reg)
      det_en && !over_now |=> deg_cnt_reg == 16'h0000 &&
      deg_pre_reg == 16'h0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Deglitch timer not restarted on current drop.");

endmodule

/* File: lock_fault_pkg.sv */
// Package with register map, field layout and timing constants of the lock fault block.
package lock_fault_pkg;

  // ===========================================================
  // Register offsets
  // ===========================================================
  localparam int ADDR_W = 8; // Width of the register address port.
  localparam logic [7:0] OFS_SETTINGS = 8'h90; // Lock fault settings.
  localparam logic [7:0] OFS_RETRY = 8'h94; // Retry time and retry limit.
  localparam logic [7:0] OFS_STATUS = 8'h98; // Read-only state view.
  localparam logic [7:0] OFS_CLEAR = 8'h9C; // Write one to clear a fault.

  // ===========================================================
  // Field positions and reset values
  // ===========================================================
  localparam int THR_LSB = 19; // Current threshold code, bits 22..19.
  localparam int MODE_LSB = 15; // Response selection, bits 18..15.
  localparam int DEG_LSB = 11; // Deglitch code, bits 14..11.
  localparam int RTIME_LSB = 0; // Retry time in ticks, bits 15..0.
  localparam int RLIMIT_LSB = 16; // Retry count limit, bits 19..16.
  localparam int CLR_BIT = 0; // Clear bit of the clear register.
  localparam logic [31:0] SETTINGS_RST = 32'h0000_0000;
  localparam logic [15:0] RTIME_RST = 16'h0000;
  localparam logic [3:0] RLIMIT_RST = 4'h0;

  // ===========================================================
  // Response selection codes
  // ===========================================================
  localparam logic [3:0] MODE_RETRY_MIN = 4'h4; // First retry code.
  localparam logic [3:0] MODE_REPORT = 4'h8; // Report only.
  localparam logic [3:0] MODE_DIS_MIN = 4'h9; // First disabling code.

  // ===========================================================
  // Timing: a 50 us tick at a 50 MHz clock
  // ===========================================================
  localparam int CLK_MHZ = 50; // Clock rate in MHz.
  localparam int TICK_US = 50; // Tick period in microseconds.
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ; // Cycles per tick.
  // Deglitch times in microseconds, indexed by the deglitch code.
  localparam int DEG_TIME_US [16] = '{50, 100, 200, 500, 1000, 2500,
    5000, 7500, 10000, 25000, 50000, 75000, 100000, 200000, 500000,
    1000000};
  // Thresholds in steps of 0.078125 A; the two reserved codes clamp.
  localparam int THR_STEPS [16] = '{1, 2, 4, 8, 12, 16, 20, 24, 28, 32,
    36, 40, 44, 48, 48, 48};

  // ===========================================================
  // Types
  // ===========================================================
  typedef enum logic [2:0] {DRV_NORMAL, DRV_TRISTATE, DRV_RECIRC,
    DRV_HS_BRAKE, DRV_LS_BRAKE} drv_state_e;
  // Command to the gate driver: hold is high while a fault owns it.
  typedef struct packed {
    logic hold;
    drv_state_e state;
  } drive_cmd_s;
  // Decoded lock settings.
  typedef struct packed {
    logic [3:0] thr;
    logic [3:0] mode;
    logic [3:0] deg;
  } lock_cfg_s;

endpackage

/* File: phase_sense_model.sv */
// Behavioural model of the phase current sensing that feeds the fault block.
`timescale 1ns/100ps
module phase_sense_model #(
  parameter int ADC_W = 12 // Width of one current sample.
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADC_W-1:0] amp_req,
  output logic [ADC_W-1:0] phase_current
);
  // ===========================================================
  // Converter pipeline
  // ===========================================================
  // A new current level shows one cycle after it is asked for, as a
  // pipelined converter would deliver it; run lengths are kept intact.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_current <= '0;
    end else begin
      phase_current <= amp_req;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking testbench of the lock current-limit fault block.
`timescale 1ns/100ps
module tb;
  // ===========================================================
  // Signals and counters
  // ===========================================================
  localparam int TICK = 2; // Short tick keeps deglitch and retry runs brief.
  localparam logic [11:0] HI = 12'h020; // Threshold code 2: 4 steps of 8.
  logic clk;
  logic nrst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [11:0] amp_req; // Current level asked of the sensing model.
  logic [11:0] phase_current;
  lock_fault_pkg::drive_cmd_s drive_cmd;
  logic fault_out_n;
  logic [31:0] rv; // Last value read back.
  int n_mismatch;
  int cmp_count;

  lock_current_limit_fault #(.ADC_W(12), .ADC_PER_STEP(8),
    .TICK_CYCLES(TICK)) u_lock_current_limit_fault (.clk(clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .phase_current(phase_current), .drive_cmd(drive_cmd),
    .fault_out_n(fault_out_n));

  phase_sense_model #(.ADC_W(12)) u_phase_sense_model (.clk(clk),
    .nrst(nrst), .amp_req(amp_req), .phase_current(phase_current));

  // ===========================================================
  // Helpers
  // ===========================================================
  // Clock generator at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints counts and verdict; the only place the run ends.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Four-state compare so an unknown never passes for a match.
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, signals changed right after an edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; sampled there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Holds the current at level a for n cycles, then drops it.
  task automatic pulse(input int n, input logic [11:0] a);
    @(posedge clk);
    amp_req <= a;
    repeat (n) @(posedge clk);
    amp_req <= 12'h000;
  endtask

  // Lets n edges pass and samples just after the last one.
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the fault pin; running out ends the run.
  task automatic wait_fault(input logic lvl, input int bound);
    int i;
    // Step off the launching edge so the pin is settled when looked at.
    #1;
    i = 0;
    while (fault_out_n !== lvl && i < bound) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("fault_out_n", 32'(lvl), 32'(fault_out_n));
    if (fault_out_n !== lvl) begin
      test_done();
    end
  endtask

  // Compares the gate driver command with what the response demands.
  task automatic chk_drv(input int hold, input int state);
    chk("drive_hold", 32'(hold), 32'(drive_cmd.hold));
    chk("drive_state", 32'(state), 32'(drive_cmd.state));
  endtask

  // Builds a settings word from threshold, response and deglitch codes.
  function automatic logic [31:0] cfg(input int t, input int m,
      input int d);
    cfg = 32'h0;
    cfg[lock_fault_pkg::THR_LSB +: 4] = 4'(t);
    cfg[lock_fault_pkg::MODE_LSB +: 4] = 4'(m);
    cfg[lock_fault_pkg::DEG_LSB +: 4] = 4'(d);
  endfunction

  // A clear write releases any latched fault and the retry count.
  task automatic clear_fault();
    wr(lock_fault_pkg::OFS_CLEAR, 32'h0000_0001);
    idle(2);
    chk("fault_out_n", 32'h1, 32'(fault_out_n));
    chk_drv(0, 0);
  endtask

  // Watchdog: a hang counts as a mismatch and closes the run.
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  // ===========================================================
  // Main sequence
  // ===========================================================
  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    amp_req = 12'h000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    idle(3);
    // Reset state: pin released, driver free, settings fields at zero.
    chk("fault_out_n", 32'h1, 32'(fault_out_n));
    chk_drv(0, 0);
    rd(lock_fault_pkg::OFS_SETTINGS, rv);
    chk("settings", lock_fault_pkg::SETTINGS_RST, rv);
    wr(lock_fault_pkg::OFS_SETTINGS, 32'hFFFF_FFFF);
    rd(lock_fault_pkg::OFS_SETTINGS, rv);
    chk("settings", 32'hFFFF_FFFF, rv);
    // Read data stand one cycle only and then return to zero.
    idle(1);
    chk("rdata_idle", 32'h0, reg_rdata);
    rd(8'h00, rv);
    chk("unmapped", 32'h0, rv);
    rd(lock_fault_pkg::OFS_CLEAR, rv);
    chk("clear_reg", 32'h0, rv);
    $display("test registers done");

    // Threshold: one count below never trips, the exact value does.
    wr(lock_fault_pkg::OFS_SETTINGS, cfg(2, 0, 0));
    pulse(20, HI - 12'h001);
    idle(6);
    chk("fault_out_n", 32'h1, 32'(fault_out_n));
    pulse(TICK, HI);
    wait_fault(1'b0, 10);
    clear_fault();
    $display("test threshold done");

    // Deglitch code 1 needs two ticks; a one-cycle dip restarts it.
    wr(lock_fault_pkg::OFS_SETTINGS, cfg(2, 0, 1));
    pulse(2 * TICK - 1, HI);
    pulse(2 * TICK - 1, HI);
    idle(6);
    chk("fault_out_n", 32'h1, 32'(fault_out_n));
    pulse(2 * TICK, HI);
    wait_fault(1'b0, 10);
    clear_fault();
    $display("test deglitch done");

    // Latched responses hold pin and driver state until cleared.
    for (int m = 0; m < 4; m++) begin
      wr(lock_fault_pkg::OFS_SETTINGS, cfg(2, m, 0));
      pulse(TICK, HI);
      wait_fault(1'b0, 10);
      idle(12);
      chk("fault_out_n", 32'h0, 32'(fault_out_n));
      chk_drv(1, m + 1);
      // Status shows the latch bit and the driver state it holds.
      rd(lock_fault_pkg::OFS_STATUS, rv);
      chk("status", {21'h0, 3'(m + 1), 7'h0, 1'b1},
        {21'h0, rv[10:8], 7'h0, rv[0]});
      clear_fault();
    end
    $display("test latched done");

    // Report only: pin asserted, driver left alone, flag readable.
    wr(lock_fault_pkg::OFS_SETTINGS, cfg(2, 8, 0));
    pulse(TICK, HI);
    wait_fault(1'b0, 10);
    chk_drv(0, 0);
    rd(lock_fault_pkg::OFS_STATUS, rv);
    chk("report_flag", 32'h1, {31'h0, rv[2]});
    clear_fault();
    $display("test report done");

    // Disabling codes: a long, strong over-current does nothing.
    for (int m = 9; m < 16; m++) begin
      wr(lock_fault_pkg::OFS_SETTINGS, cfg(2, m, 0));
      pulse(10, 12'hFFF);
      idle(6);
      chk("fault_out_n", 32'h1, 32'(fault_out_n));
      chk_drv(0, 0);
    end
    $display("test disabled done");

    // Retry: limit 2, time 3 ticks; the third event latches.
    wr(lock_fault_pkg::OFS_RETRY, 32'h0002_0003);
    rd(lock_fault_pkg::OFS_RETRY, rv);
    chk("retry_reg", 32'h0002_0003, rv);
    for (int m = 4; m < 8; m++) begin
      wr(lock_fault_pkg::OFS_SETTINGS, cfg(2, m, 0));
      for (int k = 0; k < 3; k++) begin
        pulse(TICK, HI);
        wait_fault(1'b0, 10);
        chk_drv(1, m % 4 + 1);
        if (k < 2) begin
          wait_fault(1'b1, 3 * TICK + 10);
        end else begin
          idle(3 * TICK + 12);
          chk("fault_out_n", 32'h0, 32'(fault_out_n));
          chk_drv(1, m % 4 + 1);
        end
      end
      rd(lock_fault_pkg::OFS_STATUS, rv);
      chk("retry_count", 32'h2, {28'h0, rv[7:4]});
      clear_fault();
    end
    $display("test retry done");
    test_done();
  end
endmodule
